// >>> hw/tcr_timer2.v
/*
 * Sixteen-bit timer/counter with capture, auto-reload, up/down count,
 * baud time base for serial port 0 and clock out, behind AXI4-Lite.
 * Assumes: one 125 MHz clock; the trigger and count pins are
 * asynchronous; timer 1 overflow, serial mode, interrupt enable and
 * service-entry strobes come from logic on the same clock.
 */
`timescale 1ns/1ps
`include "tcr_defs.vh"

// What this block does
// - Overflow flag on wrap or down-count match
// - Hardware sets flag only outside baud mode
// - External flag from trigger edge or down-mode overflow
// - Overflow flag or external flag requests interrupt
// - Receive time base chosen, forces baud mode
// - Transmit time base chosen, forces baud mode
// - Trigger edge captures or reloads when enabled, except in baud or down mode
// - Run bit gates counting, count preserved
// - Count clock ticks or count pin edges
// - Baud mode ticks every two clocks
// - Baud mode always auto-reloads on overflow
// - Reload mode reloads on overflow, or on trigger outside down mode
// - Capture mode copies count on trigger edge
// - Optional count clear after capture
// - Clock out enable drives clock-out pin
// - Down enable and trigger level set direction
// - Reload registers take capture or give reload
// - Hardware clears external irq flags on entry
module tcr_timer2 (
    // Clock and reset
    input wire clk_in,
    input wire rst_n_in,
    // AXI4-Lite write address
    input wire s_axi_awvalid_in,
    output wire s_axi_awready_out,
    input wire [11:0] s_axi_awaddr_in,
    // AXI4-Lite write data
    input wire s_axi_wvalid_in,
    output wire s_axi_wready_out,
    input wire [31:0] s_axi_wdata_in,
    input wire [3:0] s_axi_wstrb_in,
    // AXI4-Lite write response
    output wire s_axi_bvalid_out,
    input wire s_axi_bready_in,
    output wire [1:0] s_axi_bresp_out,
    // AXI4-Lite read address
    input wire s_axi_arvalid_in,
    output wire s_axi_arready_out,
    input wire [11:0] s_axi_araddr_in,
    // AXI4-Lite read data
    output wire s_axi_rvalid_out,
    input wire s_axi_rready_in,
    output wire [31:0] s_axi_rdata_out,
    output wire [1:0] s_axi_rresp_out,
    // Pins
    input wire external_trigger_pin_in,
    input wire count_input_pin_in,
    output wire clock_out_pin_out,
    output wire clock_out_pin_oe_out,
    // Serial port 0 time base
    input wire timer1_overflow_in,
    input wire [1:0] serial_mode_in,
    output wire rx_baud_tick_out,
    output wire tx_baud_tick_out,
    // Interrupts
    input wire timer_irq_enable_in,
    output wire timer_irq_out,
    input wire [3:0] ext_irq_entry_in,
    output wire [3:0] ext_irq_flag_clear_out
);

    reg overflow_flag_q, external_event_flag_q, rx_baud_sel_q, tx_baud_sel_q;
    reg trigger_pin_enable_q, run_control_q, counter_select_q, capture_reload_select_q;
    reg timer_speed_select_q, clock_out_q, rx_tick_q, tx_tick_q;
    reg [7:0] mode_q, w_byte_q, rdata_q, rd_byte;
    reg [15:0] reload_capture_q, count_q, count_d, reload_capture_d;
    reg trig_s1_q, trig_s2_q, trig_s3_q, cpin_s1_q, cpin_s2_q, cpin_s3_q;
    reg [3:0] presc_q, irq_clear_q, presc_div;
    reg aw_full_q, w_full_q, w_lane0_q, bvalid_q, rvalid_q;
    reg [9:0] aw_idx_q;
    reg [1:0] bresp_q, rresp_q;
    reg ovf_evt, trig_capture, rd_hit, wr_hit;
    wire baud_mode, down_mode, count_up, trig_fall, cpin_fall, presc_tick, step;
    wire trig_evt, hw_set_ovf, hw_set_exf, hw_tog_exf, timer_uses_base;
    wire do_wr, wr_ok, wr_ctrl, wr_mode, wr_rlo, wr_rhi, wr_clo, wr_chi, wr_spd;

    // Either baud select forces baud-generator mode
    assign baud_mode = rx_baud_sel_q | tx_baud_sel_q;
    // Down counting only in plain auto-reload
    assign down_mode = mode_q[`TCR_MOD_DCE] & ~capture_reload_select_q & ~baud_mode;
    // Trigger high counts up, low counts down
    assign count_up = ~down_mode | trig_s2_q;

    assign trig_fall = trig_s3_q & ~trig_s2_q;
    assign cpin_fall = cpin_s3_q & ~cpin_s2_q;

    // Tick rate: baud every two clocks, else by speed select
    always @* begin
        if (baud_mode) begin
            presc_div = `TCR_DIV_BAUD;
        end else if (timer_speed_select_q) begin
            presc_div = `TCR_DIV_FAST;
        end else begin
            presc_div = `TCR_DIV_SLOW;
        end
    end

    assign presc_tick = (presc_q == presc_div - 4'h1);
    // Run bit gates every step
    assign step = run_control_q &
                  ((baud_mode | ~counter_select_q) ? presc_tick : cpin_fall);
    // In down mode the pin is a direction, not an event
    assign trig_evt = trigger_pin_enable_q & trig_fall & ~down_mode;

    always @* begin
        count_d = count_q;
        reload_capture_d = reload_capture_q;
        ovf_evt = 1'b0;
        trig_capture = 1'b0;
        if (step) begin
            if (count_up) begin
                if (count_q == 16'hFFFF) begin
                    ovf_evt = 1'b1;
                    // Reload unless plain capture mode
                    if (baud_mode | ~capture_reload_select_q) begin
                        count_d = reload_capture_q;
                    end else begin
                        count_d = 16'h0000;
                    end
                end else begin
                    count_d = count_q + 16'h0001;
                end
            end else begin
                // Match on the reload value ends a down pass
                if (count_q == reload_capture_q) begin
                    ovf_evt = 1'b1;
                    count_d = 16'hFFFF;
                end else begin
                    count_d = count_q - 16'h0001;
                end
            end
        end
        if (trig_evt & ~baud_mode) begin
            if (capture_reload_select_q) begin
                // Capture the count as it stood
                trig_capture = 1'b1;
                reload_capture_d = count_q;
                if (mode_q[`TCR_MOD_ACL]) begin
                    count_d = 16'h0000;
                end
            end else begin
                count_d = reload_capture_q;
            end
        end
        if (wr_rlo & ~trig_capture) begin
            reload_capture_d[7:0] = w_byte_q;
        end
        if (wr_rhi & ~trig_capture) begin
            reload_capture_d[15:8] = w_byte_q;
        end
        // A software write to the count wins over the step
        if (wr_clo) begin
            count_d[7:0] = w_byte_q;
        end
        if (wr_chi) begin
            count_d[15:8] = w_byte_q;
        end
    end

    // Overflow flag never set by hardware in baud mode
    assign hw_set_ovf = ovf_evt & ~baud_mode;
    // Trigger edge sets, down-mode overflow toggles
    assign hw_set_exf = trig_evt;
    assign hw_tog_exf = ovf_evt & down_mode;

    // Serial time base needs a timer only in modes 1 and 3
    assign timer_uses_base = (serial_mode_in == `TCR_SMODE_1) |
                             (serial_mode_in == `TCR_SMODE_3);

    // Bus write path, address and data taken in either order
    assign s_axi_awready_out = ~aw_full_q;
    assign s_axi_wready_out = ~w_full_q;
    assign do_wr = aw_full_q & w_full_q & ~bvalid_q;
    assign wr_ok = do_wr & w_lane0_q;
    assign wr_ctrl = wr_ok & (aw_idx_q == `TCR_IDX_CTRL);
    assign wr_mode = wr_ok & (aw_idx_q == `TCR_IDX_MODE);
    assign wr_rlo = wr_ok & (aw_idx_q == `TCR_IDX_RCAP_LO);
    assign wr_rhi = wr_ok & (aw_idx_q == `TCR_IDX_RCAP_HI);
    assign wr_clo = wr_ok & (aw_idx_q == `TCR_IDX_CNT_LO);
    assign wr_chi = wr_ok & (aw_idx_q == `TCR_IDX_CNT_HI);
    assign wr_spd = wr_ok & (aw_idx_q == `TCR_IDX_SPEED);

    always @* begin
        wr_hit = (aw_idx_q >= `TCR_IDX_CTRL) & (aw_idx_q <= `TCR_IDX_SPEED);
    end

    // Read mux; reserved mode bit 2 reads zero
    always @* begin
        rd_byte = 8'h00;
        rd_hit = 1'b1;
        case (s_axi_araddr_in[11:2])
            `TCR_IDX_CTRL: begin
                rd_byte = {overflow_flag_q, external_event_flag_q,
                           rx_baud_sel_q, tx_baud_sel_q, trigger_pin_enable_q,
                           run_control_q, counter_select_q,
                           capture_reload_select_q};
            end
            `TCR_IDX_MODE: begin
                rd_byte = {mode_q[7:3], 1'b0, mode_q[1:0]};
            end
            `TCR_IDX_RCAP_LO: begin
                rd_byte = reload_capture_q[7:0];
            end
            `TCR_IDX_RCAP_HI: begin
                rd_byte = reload_capture_q[15:8];
            end
            `TCR_IDX_CNT_LO: begin
                rd_byte = count_q[7:0];
            end
            `TCR_IDX_CNT_HI: begin
                rd_byte = count_q[15:8];
            end
            `TCR_IDX_SPEED: begin
                rd_byte = {7'h00, timer_speed_select_q};
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            aw_full_q <= 1'b0;
            aw_idx_q <= 10'h000;
            w_full_q <= 1'b0;
            w_byte_q <= 8'h00;
            w_lane0_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= `TCR_RESP_OK;
            rvalid_q <= 1'b0;
            rdata_q <= 8'h00;
            rresp_q <= `TCR_RESP_OK;
        end else begin
            if (s_axi_awvalid_in & ~aw_full_q) begin
                aw_full_q <= 1'b1;
                aw_idx_q <= s_axi_awaddr_in[11:2];
            end else if (do_wr) begin
                aw_full_q <= 1'b0;
            end
            if (s_axi_wvalid_in & ~w_full_q) begin
                w_full_q <= 1'b1;
                w_byte_q <= s_axi_wdata_in[7:0];
                w_lane0_q <= s_axi_wstrb_in[0];
            end else if (do_wr) begin
                w_full_q <= 1'b0;
            end
            if (do_wr) begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? `TCR_RESP_OK : `TCR_RESP_ERR;
            end else if (s_axi_bready_in) begin
                bvalid_q <= 1'b0;
            end
            if (s_axi_arvalid_in & ~rvalid_q) begin
                rvalid_q <= 1'b1;
                rdata_q <= rd_byte;
                rresp_q <= rd_hit ? `TCR_RESP_OK : `TCR_RESP_ERR;
            end else if (s_axi_rready_in) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // Pins pass two flip-flops before the edge detectors
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            trig_s1_q <= 1'b1;
            trig_s2_q <= 1'b1;
            trig_s3_q <= 1'b1;
            cpin_s1_q <= 1'b1;
            cpin_s2_q <= 1'b1;
            cpin_s3_q <= 1'b1;
        end else begin
            trig_s1_q <= external_trigger_pin_in;
            trig_s2_q <= trig_s1_q;
            trig_s3_q <= trig_s2_q;
            cpin_s1_q <= count_input_pin_in;
            cpin_s2_q <= cpin_s1_q;
            cpin_s3_q <= cpin_s2_q;
        end
    end

    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            overflow_flag_q <= 1'b0;
            external_event_flag_q <= 1'b0;
            rx_baud_sel_q <= 1'b0;
            tx_baud_sel_q <= 1'b0;
            trigger_pin_enable_q <= 1'b0;
            run_control_q <= 1'b0;
            counter_select_q <= 1'b0;
            capture_reload_select_q <= 1'b0;
            mode_q <= `TCR_RST_MODE;
            timer_speed_select_q <= `TCR_RST_SPEED;
            reload_capture_q <= {`TCR_RST_BYTE, `TCR_RST_BYTE};
            count_q <= {`TCR_RST_BYTE, `TCR_RST_BYTE};
            presc_q <= 4'h0;
        end else begin
            count_q <= count_d;
            reload_capture_q <= reload_capture_d;
            // Prescaler clears while stopped so no stray tick on restart
            if (!run_control_q | presc_tick) begin
                presc_q <= 4'h0;
            end else begin
                presc_q <= presc_q + 4'h1;
            end
            // Hardware set wins over a software clear
            if (wr_ctrl) begin
                overflow_flag_q <= w_byte_q[`TCR_CTL_OVF] | hw_set_ovf;
                external_event_flag_q <= w_byte_q[`TCR_CTL_EXF] | hw_set_exf;
                rx_baud_sel_q <= w_byte_q[`TCR_CTL_RXB];
                tx_baud_sel_q <= w_byte_q[`TCR_CTL_TXB];
                trigger_pin_enable_q <= w_byte_q[`TCR_CTL_TEN];
                run_control_q <= w_byte_q[`TCR_CTL_RUN];
                counter_select_q <= w_byte_q[`TCR_CTL_CNT];
                capture_reload_select_q <= w_byte_q[`TCR_CTL_CAP];
            end else begin
                overflow_flag_q <= overflow_flag_q | hw_set_ovf;
                external_event_flag_q <= (external_event_flag_q ^ hw_tog_exf) |
                                         hw_set_exf;
            end
            if (wr_mode) begin
                mode_q <= {w_byte_q[7:3], 1'b0, w_byte_q[1:0]};
            end
            if (wr_spd) begin
                timer_speed_select_q <= w_byte_q[0];
            end
        end
    end

    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            clock_out_q <= 1'b0;
            rx_tick_q <= 1'b0;
            tx_tick_q <= 1'b0;
            irq_clear_q <= 4'h0;
        end else begin
            // Toggles per overflow, so it runs at half the overflow rate
            if (!mode_q[`TCR_MOD_COE]) begin
                clock_out_q <= 1'b0;
            end else if (ovf_evt) begin
                clock_out_q <= ~clock_out_q;
            end
            // Timer 1 or this timer's overflow
            rx_tick_q <= timer_uses_base &
                         (rx_baud_sel_q ? ovf_evt : timer1_overflow_in);
            tx_tick_q <= timer_uses_base &
                         (tx_baud_sel_q ? ovf_evt : timer1_overflow_in);
            irq_clear_q <= ext_irq_entry_in &
                           mode_q[`TCR_MOD_HC5:`TCR_MOD_HC2];
        end
    end

    assign s_axi_arready_out = ~rvalid_q;
    assign s_axi_bvalid_out = bvalid_q;
    assign s_axi_bresp_out = bresp_q;
    assign s_axi_rvalid_out = rvalid_q;
    assign s_axi_rdata_out = {24'h000000, rdata_q};
    assign s_axi_rresp_out = rresp_q;
    assign clock_out_pin_out = clock_out_q;
    assign clock_out_pin_oe_out = mode_q[`TCR_MOD_COE];
    assign rx_baud_tick_out = rx_tick_q;
    assign tx_baud_tick_out = tx_tick_q;
    // Either flag requests the interrupt while enabled
    assign timer_irq_out = timer_irq_enable_in &
                           (overflow_flag_q | external_event_flag_q);
    assign ext_irq_flag_clear_out = irq_clear_q;

endmodule

// >>> shared/tcr_defs.vh
/*
 * Constants for the capture/reload/baud timer: register indices,
 * field positions, reset values and tick divide counts.
 * Assumes inclusion by bare name from a design file.
 */
`ifndef TCR_DEFS_VH
`define TCR_DEFS_VH

// Register indices, byte address is four times the index
`define TCR_IDX_CTRL 10'h0C8
`define TCR_IDX_MODE 10'h0C9
`define TCR_IDX_RCAP_LO 10'h0CA
`define TCR_IDX_RCAP_HI 10'h0CB
`define TCR_IDX_CNT_LO 10'h0CC
`define TCR_IDX_CNT_HI 10'h0CD
`define TCR_IDX_SPEED 10'h0CE

// Control register fields
`define TCR_CTL_OVF 7
`define TCR_CTL_EXF 6
`define TCR_CTL_RXB 5
`define TCR_CTL_TXB 4
`define TCR_CTL_TEN 3
`define TCR_CTL_RUN 2
`define TCR_CTL_CNT 1
`define TCR_CTL_CAP 0

// Mode register fields
`define TCR_MOD_HC5 7
`define TCR_MOD_HC2 4
`define TCR_MOD_ACL 3
`define TCR_MOD_COE 1
`define TCR_MOD_DCE 0

// Reset values
`define TCR_RST_CTRL 8'h00
`define TCR_RST_MODE 8'h00
`define TCR_RST_BYTE 8'h00
`define TCR_RST_SPEED 1'b0

// Clocks per tick: baud mode, timer fast, timer slow
`define TCR_DIV_BAUD 4'h2
`define TCR_DIV_FAST 4'h4
`define TCR_DIV_SLOW 4'hC

// Serial port modes that use a timer time base
`define TCR_SMODE_1 2'h1
`define TCR_SMODE_3 2'h3

// AXI responses
`define TCR_RESP_OK 2'h0
`define TCR_RESP_ERR 2'h2

`endif

// >>> verif/tb_top.sv
/* Bench for the timer: bus master tasks, pin model and scenarios.
   Assumes design, checker and model compiled alongside. */
`timescale 1ns/1ps
`include "tcr_defs.vh"
module tb_top;
    logic clk_in, rst_n_in, awv, wv, bre, arv, rre, t1o, tlv, treq, creq, ien, tpin, cpin;
    logic awr, wrd, bv, arr, rv, cko, coe, rxt, txt, irq;
    logic [11:0] awa, ara;
    logic [31:0] wd, rdt;
    logic [1:0] br, rr, smode, r;
    logic [3:0] ws, ent, hclr;
    logic [7:0] rxn, txn, d, c0, c1;
    int n_fail = 0;
    int checked = 0;
    tcr_timer2 tcr_timer2_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_awaddr_in(awa),
        .s_axi_wvalid_in(wv), .s_axi_wready_out(wrd), .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws),
        .s_axi_bvalid_out(bv), .s_axi_bready_in(bre), .s_axi_bresp_out(br),
        .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_araddr_in(ara),
        .s_axi_rvalid_out(rv), .s_axi_rready_in(rre), .s_axi_rdata_out(rdt),
        .s_axi_rresp_out(rr), .external_trigger_pin_in(tpin), .count_input_pin_in(cpin),
        .clock_out_pin_out(cko), .clock_out_pin_oe_out(coe), .timer1_overflow_in(t1o),
        .serial_mode_in(smode), .rx_baud_tick_out(rxt), .tx_baud_tick_out(txt),
        .timer_irq_enable_in(ien), .timer_irq_out(irq), .ext_irq_entry_in(ent),
        .ext_irq_flag_clear_out(hclr));
    tcr_pins_model tcr_pins_model_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .trig_level_in(tlv), .trig_req_in(treq), .cnt_req_in(creq), .rx_tick_in(rxt),
        .tx_tick_in(txt), .trig_pin_out(tpin), .cnt_pin_out(cpin), .t1_ovf_out(t1o),
        .rx_n_out(rxn), .tx_n_out(txn));
    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end
    task summarize;
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task chk(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task wt(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic wr(input logic [9:0] idx, input logic [7:0] v, input logic [1:0] er = 2'h0);
        int i;
        logic a, w, b;
        @(posedge clk_in);
        awv <= 1'b1;
        wv <= 1'b1;
        awa <= {idx, 2'b00};
        wd <= {24'h000000, v};
        bre <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(negedge clk_in);
            a = awr & awv;
            w = wrd & wv;
            b = bv;
            r = br;
            @(posedge clk_in);
            if (a) awv <= 1'b0;
            if (w) wv <= 1'b0;
            if (b) break;
        end
        bre <= 1'b0;
        if (i == 50) begin
            n_fail++;
            summarize();
        end
        chk({6'h00, r}, {6'h00, er});
    endtask
    task automatic rd(input logic [9:0] idx);
        int i;
        logic a, b;
        @(posedge clk_in);
        arv <= 1'b1;
        ara <= {idx, 2'b00};
        rre <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(negedge clk_in);
            a = arr & arv;
            b = rv;
            d = rdt[7:0];
            r = rr;
            @(posedge clk_in);
            if (a) arv <= 1'b0;
            if (b) break;
        end
        rre <= 1'b0;
        if (i == 50) begin
            n_fail++;
            summarize();
        end
    endtask
    task rchk(input logic [9:0] idx, input logic [7:0] e);
        rd(idx);
        chk(d, e);
    endtask
    task fall;
        @(posedge clk_in);
        treq <= 1'b1;
        @(posedge clk_in);
        treq <= 1'b0;
        wt(10);
    endtask
    task cnt16(input logic [7:0] hi, input logic [7:0] lo);
        wr(`TCR_IDX_CNT_LO, lo);
        wr(`TCR_IDX_CNT_HI, hi);
    endtask
    task rcap16(input logic [7:0] hi, input logic [7:0] lo);
        wr(`TCR_IDX_RCAP_LO, lo);
        wr(`TCR_IDX_RCAP_HI, hi);
    endtask
    task s_regs;
        for (int k = 0; k < 7; k++) rchk(`TCR_IDX_CTRL + k[9:0], 8'h00);
        rd(10'h0CF);
        chk({6'h00, r}, {6'h00, `TCR_RESP_ERR});
        chk(d, 8'h00);
        wr(10'h0CF, 8'hFF, `TCR_RESP_ERR);
        wr(`TCR_IDX_MODE, 8'h04);
        rchk(`TCR_IDX_MODE, 8'h00);
    endtask
    task s_speed;
        wr(`TCR_IDX_SPEED, 8'h01);
        wr(`TCR_IDX_CTRL, 8'h04);
        wt(48);
        wr(`TCR_IDX_CTRL, 8'h00);
        rd(`TCR_IDX_CNT_LO);
        chk({7'h00, d >= 8'd11 && d <= 8'd14}, 8'h01);
        wt(20);
        rchk(`TCR_IDX_CNT_LO, d);
        wr(`TCR_IDX_CNT_LO, 8'h00);
        wr(`TCR_IDX_SPEED, 8'h00);
        wr(`TCR_IDX_CTRL, 8'h04);
        wt(48);
        wr(`TCR_IDX_CTRL, 8'h00);
        rd(`TCR_IDX_CNT_LO);
        chk({7'h00, d >= 8'd3 && d <= 8'd5}, 8'h01);
        wr(`TCR_IDX_CNT_LO, 8'h00);
        wr(`TCR_IDX_CTRL, 8'h06);
        repeat (5) begin
            @(posedge clk_in);
            creq <= 1'b1;
            @(posedge clk_in);
            creq <= 1'b0;
            wt(10);
        end
        wr(`TCR_IDX_CTRL, 8'h00);
        rchk(`TCR_IDX_CNT_LO, 8'h05);
    endtask
    task s_reload;
        rcap16(8'hFF, 8'hFE);
        cnt16(8'hFF, 8'hFE);
        wr(`TCR_IDX_MODE, 8'h02);
        wr(`TCR_IDX_SPEED, 8'h01);
        wr(`TCR_IDX_CTRL, 8'h04);
        wt(30);
        rchk(`TCR_IDX_CTRL, 8'h84);
        wr(`TCR_IDX_CTRL, 8'h80);
        rchk(`TCR_IDX_CNT_HI, 8'hFF);
        chk({7'h00, irq}, 8'h00);
        chk({7'h00, coe}, 8'h01);
        @(posedge clk_in);
        ien <= 1'b1;
        @(negedge clk_in);
        chk({7'h00, irq}, 8'h01);
        wr(`TCR_IDX_CTRL, 8'h00);
        rchk(`TCR_IDX_CTRL, 8'h00);
        wr(`TCR_IDX_CTRL, 8'h80);
        rchk(`TCR_IDX_CTRL, 8'h80);
        wr(`TCR_IDX_MODE, 8'h00);
    endtask
    task s_capture;
        cnt16(8'h12, 8'h34);
        chk({7'h00, cko}, 8'h00);
        wr(`TCR_IDX_CTRL, 8'h01);
        fall();
        rchk(`TCR_IDX_RCAP_LO, 8'hFE);
        rchk(`TCR_IDX_CTRL, 8'h01);
        wr(`TCR_IDX_MODE, 8'h08);
        wr(`TCR_IDX_CTRL, 8'h09);
        fall();
        rchk(`TCR_IDX_RCAP_LO, 8'h34);
        rchk(`TCR_IDX_RCAP_HI, 8'h12);
        rchk(`TCR_IDX_CNT_LO, 8'h00);
        rchk(`TCR_IDX_CNT_HI, 8'h00);
        rchk(`TCR_IDX_CTRL, 8'h49);
        wr(`TCR_IDX_MODE, 8'h00);
        cnt16(8'h00, 8'h77);
        wr(`TCR_IDX_CTRL, 8'h08);
        fall();
        rchk(`TCR_IDX_CNT_LO, 8'h34);
        rchk(`TCR_IDX_CTRL, 8'h48);
    endtask
    task s_baud;
        rcap16(8'hFF, 8'hFE);
        cnt16(8'hFF, 8'hFE);
        smode <= `TCR_SMODE_3;
        wr(`TCR_IDX_CTRL, 8'h27);
        c0 = rxn;
        c1 = txn;
        wt(100);
        chk({7'h00, rxn - c0 >= 8'd23 && rxn - c0 <= 8'd27}, 8'h01);
        chk({7'h00, txn - c1 >= 8'd9 && txn - c1 <= 8'd11}, 8'h01);
        rd(`TCR_IDX_CTRL);
        chk({7'h00, d[7]}, 8'h00);
        smode <= 2'h2;
        wt(2);
        c0 = rxn;
        wt(40);
        chk(rxn - c0, 8'h00);
        wr(`TCR_IDX_CTRL, 8'h00);
    endtask
    task s_down;
        wr(`TCR_IDX_MODE, 8'h01);
        rcap16(8'h00, 8'h05);
        cnt16(8'h00, 8'h07);
        tlv <= 1'b0;
        wr(`TCR_IDX_CTRL, 8'h04);
        wt(14);
        rd(`TCR_IDX_CTRL);
        chk({7'h00, d[7]}, 8'h01);
        wr(`TCR_IDX_CTRL, 8'h00);
        rchk(`TCR_IDX_CNT_HI, 8'hFF);
        tlv <= 1'b1;
        cnt16(8'h00, 8'h07);
        wr(`TCR_IDX_CTRL, 8'h04);
        wt(14);
        wr(`TCR_IDX_CTRL, 8'h00);
        rchk(`TCR_IDX_CNT_HI, 8'h00);
        wr(`TCR_IDX_MODE, 8'h00);
    endtask
    task s_hwclr;
        wr(`TCR_IDX_MODE, 8'h50);
        @(posedge clk_in);
        ent <= 4'hF;
        @(posedge clk_in);
        ent <= 4'h0;
        @(negedge clk_in);
        chk({4'h0, hclr}, 8'h05);
        wr(`TCR_IDX_MODE, 8'h00);
    endtask
    initial begin
        rst_n_in = 1'b0;
        {awv, wv, bre, arv, rre, treq, creq, ien} = 8'h00;
        awa = 12'h000;
        ara = 12'h000;
        wd = 32'h00000000;
        ws = 4'h1;
        tlv = 1'b1;
        smode = 2'h0;
        ent = 4'h0;
        repeat (8) @(posedge clk_in);
        rst_n_in <= 1'b1;
        s_regs();
        s_speed();
        s_reload();
        s_capture();
        s_baud();
        s_down();
        s_hwclr();
        summarize();
    end
endmodule

// >>> verif/tcr_pins_model.sv
/* Far-side model: pins, timer 1 overflow, tick counters.
   Assumes the timer's clock. */
`timescale 1ns/1ps
module tcr_pins_model (
    // Clock and reset
    input wire clk_in,
    input wire rst_n_in,
    // Requests from the bench
    input wire trig_level_in,
    input wire trig_req_in,
    input wire cnt_req_in,
    // Ticks from the timer
    input wire rx_tick_in,
    input wire tx_tick_in,
    // Pins and counts
    output wire trig_pin_out,
    output wire cnt_pin_out,
    output logic t1_ovf_out,
    output logic [7:0] rx_n_out,
    output logic [7:0] tx_n_out
);
    logic [2:0] trig_low_q;
    logic [2:0] cnt_low_q;
    logic [3:0] t1_div_q;
    // Low phases last four clocks so the synchroniser cannot miss them
    assign trig_pin_out = trig_level_in & (trig_low_q == 3'h0);
    assign cnt_pin_out = (cnt_low_q == 3'h0);
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            trig_low_q <= 3'h0;
            cnt_low_q <= 3'h0;
            t1_div_q <= 4'h0;
            t1_ovf_out <= 1'b0;
            rx_n_out <= 8'h00;
            tx_n_out <= 8'h00;
        end else begin
            trig_low_q <= trig_req_in ? 3'h4 : trig_low_q - {2'h0, trig_low_q != 3'h0};
            cnt_low_q <= cnt_req_in ? 3'h4 : cnt_low_q - {2'h0, cnt_low_q != 3'h0};
            t1_div_q <= (t1_div_q == 4'h9) ? 4'h0 : t1_div_q + 4'h1;
            t1_ovf_out <= (t1_div_q == 4'h9);
            rx_n_out <= rx_n_out + {7'h00, rx_tick_in};
            tx_n_out <= tx_n_out + {7'h00, tx_tick_in};
        end
    end
endmodule

// >>> verif/tcr_timer2_sva.sv
/* Checker for the timer: bus, interrupt, clock-out, ticks, clears.
   Assumes one clock, active-low reset. */
`timescale 1ns/1ps
module tcr_timer2_sva (
    // Clock and reset
    input wire clk_in,
    input wire rst_n_in,
    // Bus
    input wire s_axi_awvalid_in,
    input wire s_axi_awready_out,
    input wire s_axi_wvalid_in,
    input wire s_axi_wready_out,
    input wire s_axi_bvalid_out,
    input wire s_axi_bready_in,
    input wire s_axi_arvalid_in,
    input wire s_axi_arready_out,
    input wire s_axi_rvalid_out,
    input wire s_axi_rready_in,
    input wire [31:0] s_axi_rdata_out,
    // Timer side
    input wire [1:0] serial_mode_in,
    input wire rx_baud_tick_out,
    input wire tx_baud_tick_out,
    input wire timer_irq_enable_in,
    input wire timer_irq_out,
    input wire clock_out_pin_out,
    input wire clock_out_pin_oe_out,
    input wire [3:0] ext_irq_entry_in,
    input wire [3:0] ext_irq_flag_clear_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    chk_b_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
        else $error("write response dropped before bready");
    chk_r_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in
        |=> s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read data not held");
    chk_ar_block: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
        else $error("read address taken while data pending");
    chk_r_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
        else $error("read answer late");
    chk_w_answer: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
        && s_axi_wready_out && !s_axi_bvalid_out |-> ##2 s_axi_bvalid_out)
        else $error("write answer not two cycles after taking");
    chk_r_upper: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h000000)
        else $error("read data upper bits set");
    chk_irq_gate: assert property (!timer_irq_enable_in |-> !timer_irq_out)
        else $error("interrupt while disabled");
    chk_clk_out_off: assert property (!clock_out_pin_oe_out && !$past(clock_out_pin_oe_out)
        |-> !clock_out_pin_out) else $error("clock out active while disabled");
    chk_hw_clear: assert property (ext_irq_flag_clear_out != 4'h0
        |-> (ext_irq_flag_clear_out & ~$past(ext_irq_entry_in)) == 4'h0)
        else $error("hardware clear without service entry");
    chk_baud_tick: assert property (!serial_mode_in[0] && !$past(serial_mode_in[0])
        |-> !(rx_baud_tick_out || tx_baud_tick_out)) else $error("baud tick outside modes 1 and 3");
endmodule

bind tcr_timer2 tcr_timer2_sva tcr_timer2_sva_inst (.*);
